// File: design/npic_ctrl.sv
// Purpose: Nested priority interrupt controller with current-level handling
// Assumes: Single clock hclk at 50 MHz, AHB-Lite slave, CPU gives one-cycle ops
// Notes:   Peripheral flags arrive as levels; external pins are synchronised
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Four priority registers reset to all ones
// - Vectors 0..13 map to two-bit fields
// - Fields use CPU level bit encoding
// - Level codes: main 10, 01, 00, disabled 11
// - Level 0 writes to a field ignored
// - Reset or trap service sets level 11
// - Raised priority of running pending vector re-enters
// - Unmask, wait, halt load level 10
// - Mask and trap load level 11
// - Return restores levels from stack
// - Pop condition codes loads levels
// - Branch flags: masked and unmasked
// - Level changes persist until next change
// - Vector 1 highest, vector 11 lowest
// - Clock security shares vector 1
// - External groups on vectors 2 to 5
// - Serial, timers, async serial on 7..10
// - Halt wake only from listed sources
// - Vector 1 sources wake active halt
// - Two external sensitivities, each shared by two groups
// - Edge modes; rising plus high groups 0,2
// - Sensitivity writes only at level 3
// - Changed sensitivity clears external pending
// - Polarity bit inverts port sensitivity
// - Highest software then hardware priority wins
// - Serve only enabled and above current level
module npic_ctrl
  import npic_pkg::*;
(
  // Clock and reset
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  // AHB-Lite slave
  input  wire  logic        hsel,
  input  wire  logic [7:0]  haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output var   logic        hreadyout,
  output var   logic        hresp,
  output var   logic [31:0] hrdata,
  // Sources
  input  wire  logic        clk_time_base_irq,
  input  wire  logic        clock_security_irq,
  input  wire  logic [3:0]  ext_port_a,
  input  wire  logic [2:0]  ext_port_f,
  input  wire  logic [7:0]  ext_port_b,
  input  wire  logic        spi_irq,
  input  wire  logic        spi_slave_mode,
  input  wire  logic        timer_a_irq,
  input  wire  logic        timer_b_irq,
  input  wire  logic        sci_irq,
  input  wire  logic        aux_voltage_irq,
  input  wire  logic [13:0] vec_enable,
  // CPU side
  input  wire  logic [2:0]  cpu_op,
  input  wire  logic [1:0]  cpu_stack_level,
  input  wire  logic        cpu_ack,
  input  wire  logic        cpu_in_halt,
  input  wire  logic        cpu_active_halt,
  output var   logic        irq_req,
  output var   logic [15:0] irq_vector,
  output var   logic [1:0]  irq_prio,
  output var   logic [1:0]  cur_level,
  output var   logic        branch_if_masked,
  output var   logic        branch_if_unmasked,
  output var   logic        halt_wake
);

  // Priority registers, packed as 32 bits (two per vector, bank3 top ro)
  logic [31:0] prio_reg, prio_next;
  logic [7:0]  extctl_reg, extctl_next;     // External control
  logic [1:0]  level_reg, level_next;       // Current level bits
  logic [3:0]  ext_pend_reg, ext_pend_next; // Latched external requests
  logic [13:0] run_reg, run_next;           // Vectors in service
  // Bus pipeline
  logic        wr_pend_reg, wr_pend_next;
  logic [7:0]  addr_reg, addr_next;
  logic [31:0] rdata_reg, rdata_next;
  // Output registers
  logic        req_reg, req_next;
  logic [15:0] vec_reg, vec_next;
  logic [1:0]  oprio_reg, oprio_next;
  logic        wake_reg, wake_next;
  logic        masked_reg, masked_next;     // Branch flag, level 3 held
  logic        unmasked_reg, unmasked_next; // Branch flag, below level 3
  // Synchronisers for pins: three stages
  logic [14:0] s1_reg, s2_reg, s3_reg, pin_prev_reg;

  // Level ordering: higher number means higher level
  function automatic logic [1:0] lvl_rank(input logic [1:0] code);
    unique case (code)
      NPIC_LVL0: lvl_rank = 2'h0;
      NPIC_LVL1: lvl_rank = 2'h1;
      NPIC_LVL2: lvl_rank = 2'h2;
      NPIC_LVL3: lvl_rank = 2'h3;
    endcase
  endfunction

  // Edge and level detection per group
  function automatic logic sense(input logic [1:0] mode, input logic inv,
                                 input logic now, input logic prev);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = ~now & prev;
    sense = 1'b0;
    unique case (mode)
      NPIC_SENS_FALL_LOW: sense = inv ? (rise | now) : (fall | ~now);
      NPIC_SENS_RISE:     sense = inv ? fall : rise;
      NPIC_SENS_FALL:     sense = inv ? rise : fall;
      NPIC_SENS_BOTH:     sense = rise | fall;
    endcase
  endfunction

  // Pin synchroniser: only stage2/3 agreement is used
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // Idle pins sit high; all stages match so no false edge follows reset
      s1_reg       <= 15'h7fff;
      s2_reg       <= 15'h7fff;
      s3_reg       <= 15'h7fff;
      pin_prev_reg <= 15'h7fff;
    end
    else
    begin
      s1_reg <= {ext_port_b, ext_port_f, ext_port_a};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Accept a new value once two stages agree
      for (int i = 0; i < 15; i++)
        if (s2_reg[i] == s3_reg[i])
          pin_prev_reg[i] <= s3_reg[i];
    end
  end

  // Stable pin values and group edge samples
  logic [14:0] pin_now;
  logic [3:0]  grp_now, grp_hit;
  always_comb
  begin
    for (int i = 0; i < 15; i++)
      pin_now[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : pin_prev_reg[i];
    grp_hit = 4'h0;
    grp_now = 4'h0;
    // Group lines ORed; each line checked on its own
    for (int i = 0; i < 4; i++)
      grp_hit[0] |= sense(extctl_reg[NPIC_IS2_POS +: 2], extctl_reg[NPIC_IPA_POS],
                          pin_now[i], pin_prev_reg[i]);
    for (int i = 4; i < 7; i++)
      grp_hit[1] |= sense(extctl_reg[NPIC_IS2_POS +: 2], 1'b0,
                          pin_now[i], pin_prev_reg[i]);
    for (int i = 7; i < 11; i++)
      grp_hit[2] |= sense(extctl_reg[NPIC_IS1_POS +: 2], extctl_reg[NPIC_IPB_POS],
                          pin_now[i], pin_prev_reg[i]);
    for (int i = 11; i < 15; i++)
      grp_hit[3] |= sense(extctl_reg[NPIC_IS1_POS +: 2], 1'b0,
                          pin_now[i], pin_prev_reg[i]);
    grp_now = grp_hit;
  end

  // Pending vector set, vectors 0, 6, 12 and 13 unused
  logic [13:0] pend;
  logic [13:0] wake_ok;
  logic        halted;                               // Either halt flavour
  always_comb
  begin
    halted = cpu_in_halt | cpu_active_halt;
    pend = 14'h0000;
    pend[1]  = clk_time_base_irq | clock_security_irq;
    pend[5:2] = ext_pend_reg;
    pend[7]  = spi_irq;
    pend[8]  = timer_a_irq;
    pend[9]  = timer_b_irq;
    pend[10] = sci_irq;
    pend[11] = aux_voltage_irq;
    // Halt wake capable sources
    wake_ok = 14'h0000;
    // Time base only runs on in active halt, so plain halt cannot use it
    wake_ok[1] = cpu_active_halt;
    wake_ok[5:2] = 4'hf;
    wake_ok[7] = spi_slave_mode;
  end

  // Arbitration: software priority then lowest vector number
  logic [13:0] elig;
  logic        win_v;
  logic [3:0]  win_i;
  logic [1:0]  win_p;
  always_comb
  begin
    win_v = 1'b0;
    win_i = 4'h0;
    win_p = NPIC_LVL2;
    for (int i = 0; i < NPIC_NVEC; i++)
    begin
      // Above current level, or rewritten higher while running
      elig[i] = pend[i] & vec_enable[i] & (!halted || wake_ok[i]) &
                (lvl_rank(prio_reg[2*i +: 2]) > lvl_rank(level_reg));
    end
    for (int i = NPIC_NVEC - 1; i >= 0; i--)
      if (elig[i] && (!win_v ||
          lvl_rank(prio_reg[2*i +: 2]) >= lvl_rank(win_p)))
      begin
        win_v = 1'b1;
        win_i = 4'(i);
        win_p = prio_reg[2*i +: 2];
      end
  end

  // Address phase taken when selected and the bus is ready
  logic        wr_now;
  always_comb
  begin
    wr_now = hsel & hready & htrans[1];
  end

  // Next state for registers, level and pending
  always_comb
  begin
    prio_next    = prio_reg;
    extctl_next  = extctl_reg;
    level_next   = level_reg;
    ext_pend_next = ext_pend_reg | grp_now;            // Set wins
    run_next     = run_reg;
    wr_pend_next = wr_now & hwrite;
    addr_next    = wr_now ? haddr : addr_reg;
    rdata_next   = rdata_reg;
    req_next     = win_v & ~cpu_ack;
    vec_next     = NPIC_VEC_BASE - {11'h000, win_i, 1'b0};
    oprio_next   = win_p;
    wake_next    = halted & |(pend & wake_ok & vec_enable);
    // Register writes in data phase
    if (wr_pend_reg)
    begin
      for (int b = 0; b < 4; b++)
        if (addr_reg == NPIC_PRIO0_ADDR + 8'(4*b))
          for (int f = 0; f < 4; f++)
            if (hwdata[2*f +: 2] != NPIC_LVL0)
              prio_next[8*b + 2*f +: 2] = hwdata[2*f +: 2];
      prio_next[31:28] = 4'hf;
      if (addr_reg == NPIC_EXTCTL_ADDR && level_reg == NPIC_LVL3)
      begin
        extctl_next = hwdata[7:0] & NPIC_EXTCTL_MASK;
        if (extctl_next != extctl_reg)
          ext_pend_next = grp_now;
      end
    end
    // Level changes from the CPU; persist until next one
    unique case (npic_op_t'(cpu_op))
      NPIC_OP_UNMASK, NPIC_OP_WFI, NPIC_OP_HALT: level_next = NPIC_LVL0;
      NPIC_OP_MASK, NPIC_OP_TRAP: level_next = NPIC_LVL3;
      NPIC_OP_RET, NPIC_OP_POPCC: level_next = cpu_stack_level;
      NPIC_OP_NONE: ;
    endcase
    if (cpu_op == NPIC_OP_RET && run_reg != 14'h0000)
      for (int i = 0; i < NPIC_NVEC; i++)
        if (run_reg[i])
          run_next[i] = 1'b0;
    // Entry: load vector priority, edge group latch clears
    if (cpu_ack && req_reg)
    begin
      level_next = oprio_reg;
      for (int i = 2; i < 6; i++)
        if (vec_reg == NPIC_VEC_BASE - 16'(2*i))
          ext_pend_next[i-2] = grp_now[i-2];
      for (int i = 0; i < NPIC_NVEC; i++)
        if (vec_reg == NPIC_VEC_BASE - 16'(2*i))
          run_next[i] = 1'b1;
    end
    // Branch flags follow the level that will be held
    masked_next   = (level_next == NPIC_LVL3);
    unmasked_next = (level_next != NPIC_LVL3);
    // Read data
    if (wr_now && !hwrite)
    begin
      rdata_next = 32'h0000_0000;
      unique case (haddr)
        NPIC_PRIO0_ADDR: rdata_next[7:0] = prio_reg[7:0];
        NPIC_PRIO1_ADDR: rdata_next[7:0] = prio_reg[15:8];
        NPIC_PRIO2_ADDR: rdata_next[7:0] = prio_reg[23:16];
        NPIC_PRIO3_ADDR: rdata_next[7:0] = prio_reg[31:24] | NPIC_PRIO3_RO_ONES;
        NPIC_EXTCTL_ADDR: rdata_next[7:0] = extctl_reg;
        NPIC_LEVEL_ADDR: rdata_next[1:0] = level_reg;
        NPIC_PEND_ADDR: rdata_next[13:0] = pend;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prio_reg     <= {4{NPIC_PRIO_RESET}};
      extctl_reg   <= NPIC_EXTCTL_RESET;
      level_reg    <= NPIC_LVL3;
      ext_pend_reg <= 4'h0;
      run_reg      <= 14'h0000;
      wr_pend_reg  <= 1'b0;
      addr_reg     <= 8'h00;
      rdata_reg    <= 32'h0000_0000;
      req_reg      <= 1'b0;
      vec_reg      <= NPIC_VEC_RESET;
      oprio_reg    <= NPIC_LVL3;
      wake_reg     <= 1'b0;
      masked_reg   <= 1'b1;
      unmasked_reg <= 1'b0;
    end
    else
    begin
      prio_reg     <= prio_next;
      extctl_reg   <= extctl_next;
      level_reg    <= level_next;
      ext_pend_reg <= ext_pend_next;
      run_reg      <= run_next;
      wr_pend_reg  <= wr_pend_next;
      addr_reg     <= addr_next;
      rdata_reg    <= rdata_next;
      req_reg      <= req_next;
      vec_reg      <= vec_next;
      oprio_reg    <= oprio_next;
      wake_reg     <= wake_next;
      masked_reg   <= masked_next;
      unmasked_reg <= unmasked_next;
    end
  end

  // Outputs straight from flip-flops, ready and response tied off; zero-wait slave
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;
  assign irq_req   = req_reg;
  assign irq_vector = vec_reg;
  assign irq_prio  = oprio_reg;
  assign cur_level = level_reg;
  assign branch_if_masked   = masked_reg;
  assign branch_if_unmasked = unmasked_reg;
  assign halt_wake = wake_reg;

  // Checks
  sequence s_mask_op;
    cpu_op == NPIC_OP_MASK && !cpu_ack;
  endsequence
  sequence s_unmask_op;
    cpu_op == NPIC_OP_UNMASK && !cpu_ack;
  endsequence
  mask_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_mask_op |=> cur_level == 2'h3) else $error("mask op did not set 11");
  unmask_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_unmask_op |=> cur_level == 2'h2) else $error("unmask op did not set 10");
  prio3_top_a: assert property (@(posedge hclk) disable iff (!hresetn)
    prio_reg[31:28] == 4'hf) else $error("bank3 upper bits not ones");
  no_level0_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_reg && hwdata[1:0] == 2'h2 && addr_reg == 8'h00
    |=> $stable(prio_reg[1:0])) else $error("level 0 field stored");
  ext_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    level_reg != 2'h3 |=> $stable(extctl_reg)) else $error("sense changed unmasked");
  branch_pair_a: assert property (@(posedge hclk) disable iff (!hresetn)
    branch_if_masked != branch_if_unmasked) else $error("branch flags agree");
  entry_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cpu_ack && req_reg |=> cur_level == $past(oprio_reg)) else $error("entry level wrong");
  serve_above_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_next |-> lvl_rank(win_p) > lvl_rank(level_reg)) else $error("served at or below level");
  ret_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cpu_op == NPIC_OP_RET && !cpu_ack |=> cur_level == $past(cpu_stack_level))
    else $error("return did not restore level");
  reenter_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_next && run_reg[win_i] |-> lvl_rank(win_p) > lvl_rank(level_reg))
    else $error("running vector re-entered without raised priority");

endmodule
`default_nettype wire

// File: design/npic_pkg.sv
// Purpose: Shared constants for the nested priority interrupt controller
// Assumes: AHB-Lite register access, 32-bit data, one word per register
// Notes:   Priority level codes match the CPU current-level bit pair
package npic_pkg;
  // Register byte addresses
  localparam logic [7:0] NPIC_PRIO0_ADDR = 8'h00;
  localparam logic [7:0] NPIC_PRIO1_ADDR = 8'h04;
  localparam logic [7:0] NPIC_PRIO2_ADDR = 8'h08;
  localparam logic [7:0] NPIC_PRIO3_ADDR = 8'h0c;
  localparam logic [7:0] NPIC_EXTCTL_ADDR = 8'h10;
  localparam logic [7:0] NPIC_LEVEL_ADDR = 8'h14;
  localparam logic [7:0] NPIC_PEND_ADDR = 8'h18;
  // Reset values
  localparam logic [7:0] NPIC_PRIO_RESET = 8'hff;
  localparam logic [7:0] NPIC_PRIO3_RO_ONES = 8'hf0;
  localparam logic [7:0] NPIC_EXTCTL_RESET = 8'h00;
  // External control field positions
  localparam int NPIC_IS1_POS = 6;
  localparam int NPIC_IPB_POS = 5;
  localparam int NPIC_IS2_POS = 3;
  localparam int NPIC_IPA_POS = 2;
  localparam logic [7:0] NPIC_EXTCTL_MASK = 8'hfc;
  // Level codes (hi,lo)
  localparam logic [1:0] NPIC_LVL0 = 2'h2;
  localparam logic [1:0] NPIC_LVL1 = 2'h1;
  localparam logic [1:0] NPIC_LVL2 = 2'h0;
  localparam logic [1:0] NPIC_LVL3 = 2'h3;
  // Sensitivity codes
  localparam logic [1:0] NPIC_SENS_FALL_LOW = 2'h0;
  localparam logic [1:0] NPIC_SENS_RISE = 2'h1;
  localparam logic [1:0] NPIC_SENS_FALL = 2'h2;
  localparam logic [1:0] NPIC_SENS_BOTH = 2'h3;
  // Vector addresses
  localparam logic [15:0] NPIC_VEC_RESET = 16'hfffe;
  localparam logic [15:0] NPIC_VEC_TRAP = 16'hfffc;
  localparam logic [15:0] NPIC_VEC_BASE = 16'hfffa;
  localparam int NPIC_NVEC = 14;
  // CPU level instruction codes
  typedef enum logic [2:0]
  {
    NPIC_OP_NONE = 3'h0,
    NPIC_OP_UNMASK = 3'h1,
    NPIC_OP_MASK = 3'h2,
    NPIC_OP_WFI = 3'h3,
    NPIC_OP_HALT = 3'h4,
    NPIC_OP_TRAP = 3'h5,
    NPIC_OP_RET = 3'h6,
    NPIC_OP_POPCC = 3'h7
  } npic_op_t;
endpackage

// File: tb/npic_cpu_model.sv
// Purpose: Behavioural CPU core on the far side of the controller
// Assumes: Ops last one cycle and start just after a rising edge
// Notes:   Popped level is meaningless outside return and pop ops
`timescale 1ns/1ps
`default_nettype none
module npic_cpu_model
  import npic_pkg::*;
(
  // Clock
  input  wire logic       hclk,
  // Core outputs
  output var  logic [2:0] cpu_op,
  output var  logic [1:0] cpu_stack_level,
  output var  logic       cpu_ack,
  output var  logic       cpu_in_halt,
  output var  logic       cpu_active_halt
);
  // Quiet core at time zero
  initial
  begin
    cpu_op = NPIC_OP_NONE;
    cpu_stack_level = 2'h1;
    cpu_ack = 1'b0;
    cpu_in_halt = 1'b0;
    cpu_active_halt = 1'b0;
  end
  // One instruction; halt state follows the last op
  task automatic do_op(input logic [2:0] op, input logic [1:0] lvl);
    cpu_op <= op;
    cpu_stack_level <= lvl;
    cpu_in_halt <= (op == NPIC_OP_HALT);
    @(posedge hclk);
    cpu_op <= NPIC_OP_NONE;
    // Stale stack value is inverted so it differs from the last popped level
    cpu_stack_level <= ~lvl;
    @(posedge hclk);
  endtask
  // Entry takes the presented vector in a single cycle
  task automatic take_irq();
    cpu_ack <= 1'b1;
    cpu_in_halt <= 1'b0;
    @(posedge hclk);
    cpu_ack <= 1'b0;
    @(posedge hclk);
  endtask
  // Halt flavour; active halt keeps the time base running
  task automatic set_active(input logic a);
    cpu_active_halt <= a;
    @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: Self-checking bench for the nested interrupt controller
// Assumes: Zero-wait AHB-Lite slave, level peripheral requests
// Notes:   Source table order is time base, security, spi, timers, sci, avd
`timescale 1ns/1ps
`default_nettype none
module tb
  import npic_pkg::*;
;
  // Bus and reset
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  // Sources and pins
  logic [6:0]  src;
  logic        spi_slave_mode;
  logic [3:0]  ext_port_a;
  logic [2:0]  ext_port_f;
  logic [7:0]  ext_port_b;
  logic [13:0] vec_enable;
  // Core side
  logic [2:0]  cpu_op;
  logic [1:0]  cpu_stack_level, irq_prio, cur_level;
  logic        cpu_ack, cpu_in_halt, cpu_active_halt, irq_req;
  logic        branch_if_masked, branch_if_unmasked, halt_wake;
  logic [15:0] irq_vector;
  // Bookkeeping and tables
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          i;
  int          vn [7] = '{1, 1, 7, 8, 9, 10, 11};
  logic [2:0]  op_t [7] = '{NPIC_OP_UNMASK, NPIC_OP_MASK, NPIC_OP_WFI, NPIC_OP_HALT,
                            NPIC_OP_TRAP, NPIC_OP_RET, NPIC_OP_POPCC};
  logic [1:0]  lv_t [7] = '{NPIC_LVL0, NPIC_LVL3, NPIC_LVL0, NPIC_LVL0,
                            NPIC_LVL3, NPIC_LVL1, NPIC_LVL2};

  // Device under test; hready loops back from the only slave
  npic_ctrl npic_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .clk_time_base_irq(src[0]), .clock_security_irq(src[1]), .spi_irq(src[2]),
    .timer_a_irq(src[3]), .timer_b_irq(src[4]), .sci_irq(src[5]),
    .aux_voltage_irq(src[6]), .spi_slave_mode, .ext_port_a, .ext_port_f, .ext_port_b,
    .vec_enable, .cpu_op, .cpu_stack_level, .cpu_ack, .cpu_in_halt, .cpu_active_halt,
    .irq_req, .irq_vector, .irq_prio, .cur_level, .branch_if_masked,
    .branch_if_unmasked, .halt_wake);
  // Core model
  npic_cpu_model npic_cpu_model_i (.hclk, .cpu_op, .cpu_stack_level, .cpu_ack,
    .cpu_in_halt, .cpu_active_halt);

  // 50 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // Verdict and end of run
  task automatic close_out();
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Bounded wait for a flag seen high at an edge
  task automatic wait_hi(ref logic s, input string nm);
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (s !== 1'b1 && n < 60);
    if (s !== 1'b1)
    begin
      $display("Error %s expected 1 seen %b", nm, s);
      n_mismatch++;
      close_out();
    end
  endtask
  // One single AHB transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_hi(hreadyout, "hready");
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_hi(hreadyout, "hready");
    q = hrdata;
  endtask
  // Register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // Register read compare
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    n_checks++;
    if (q !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, q);
      n_mismatch++;
    end
  endtask
  // Port value compare
  task automatic chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  // Let a request through and enter it, checking vector, priority and entry level
  task automatic serve(input int v, input logic [1:0] p);
    wait_hi(irq_req, "irq_req");
    chk_v("vector", NPIC_VEC_BASE - 16'(2 * v), irq_vector);
    chk_v("prio", 16'(p), 16'(irq_prio));
    npic_cpu_model_i.take_irq();
    chk_v("entry level", 16'(p), 16'(cur_level));
  endtask

  // Main sequence
  initial
  begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    src = '0;
    spi_slave_mode = 1'b0;
    ext_port_a = 4'hf;
    ext_port_f = 3'h7;
    ext_port_b = 8'hff;
    vec_enable = 14'h3fff;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset state, map and unmapped access
    for (i = 0; i < 4; i++)
      rd_chk("prio bank", NPIC_PRIO0_ADDR + 8'(4 * i), 32'hff);
    chk_v("reset level", 16'(NPIC_LVL3), 16'(cur_level));
    rd_chk("ext ctl", NPIC_EXTCTL_ADDR, 32'h0);
    wr(8'h1c, 32'h5a);
    chk_v("hresp", 16'h0, 16'(hresp));
    // Level 0 fields keep old value, upper bank3 bits read one
    wr(NPIC_PRIO0_ADDR, 32'hcf);
    wr(NPIC_PRIO0_ADDR, 32'h64);
    rd_chk("prio bank0", NPIC_PRIO0_ADDR, 32'h44);
    wr(NPIC_PRIO3_ADDR, 32'h00);
    rd_chk("prio bank3", NPIC_PRIO3_ADDR, 32'hf0);
    wr(NPIC_PRIO0_ADDR, 32'hff);
    // Level instructions and branch flags
    for (i = 0; i < 7; i++)
    begin
      npic_cpu_model_i.do_op(op_t[i], lv_t[i]);
      repeat (3) @(posedge hclk);
      chk_v("cur_level", 16'(lv_t[i]), 16'(cur_level));
      chk_v("masked", 16'(lv_t[i] == NPIC_LVL3), 16'(branch_if_masked));
      chk_v("unmasked", 16'(lv_t[i] != NPIC_LVL3), 16'(branch_if_unmasked));
    end
    // Each source alone at default level 3
    npic_cpu_model_i.do_op(NPIC_OP_UNMASK, NPIC_LVL0);
    for (i = 0; i < 7; i++)
    begin
      src[i] <= 1'b1;
      serve(vn[i], NPIC_LVL3);
      src[i] <= 1'b0;
      npic_cpu_model_i.do_op(NPIC_OP_RET, NPIC_LVL0);
    end
    // Software priority beats hardware order; lower one stays pending
    wr(NPIC_PRIO2_ADDR, 32'hf1);
    src[3] <= 1'b1;
    src[5] <= 1'b1;
    serve(10, NPIC_LVL3);
    repeat (3) @(posedge hclk);
    chk_v("irq_req", 16'h0, 16'(irq_req));
    src[5] <= 1'b0;
    npic_cpu_model_i.do_op(NPIC_OP_RET, NPIC_LVL0);
    serve(8, NPIC_LVL1);
    // Raised priority while running and still pending re-enters
    wr(NPIC_PRIO2_ADDR, 32'hf3);
    serve(8, NPIC_LVL3);
    src[3] <= 1'b0;
    npic_cpu_model_i.do_op(NPIC_OP_RET, NPIC_LVL0);
    // Port A low level and falling edge on default sensitivity
    ext_port_a[0] <= 1'b0;
    wait_hi(irq_req, "irq_req");
    ext_port_a[0] <= 1'b1;
    repeat (5) @(posedge hclk);
    serve(2, NPIC_LVL3);
    npic_cpu_model_i.do_op(NPIC_OP_RET, NPIC_LVL0);
    // Sensitivity writes refused outside level 3
    wr(NPIC_EXTCTL_ADDR, 32'h10);
    rd_chk("ext ctl", NPIC_EXTCTL_ADDR, 32'h0);
    npic_cpu_model_i.do_op(NPIC_OP_MASK, NPIC_LVL0);
    wr(NPIC_EXTCTL_ADDR, 32'h10);
    rd_chk("ext ctl", NPIC_EXTCTL_ADDR, 32'h10);
    // A latched port F edge is dropped by a changed sensitivity
    ext_port_f[0] <= 1'b0;
    repeat (6) @(posedge hclk);
    wr(NPIC_EXTCTL_ADDR, 32'h08);
    npic_cpu_model_i.do_op(NPIC_OP_UNMASK, NPIC_LVL0);
    repeat (6) @(posedge hclk);
    chk_v("irq_req", 16'h0, 16'(irq_req));
    ext_port_f[0] <= 1'b1;
    serve(3, NPIC_LVL3);
    npic_cpu_model_i.do_op(NPIC_OP_MASK, NPIC_LVL0);
    // Port A inverted: rising-only becomes falling-only
    wr(NPIC_EXTCTL_ADDR, 32'h0c);
    npic_cpu_model_i.do_op(NPIC_OP_UNMASK, NPIC_LVL0);
    ext_port_a[0] <= 1'b0;
    serve(2, NPIC_LVL3);
    ext_port_a[0] <= 1'b1;
    npic_cpu_model_i.do_op(NPIC_OP_RET, NPIC_LVL0);
    // Port B high group on both edges: fall then rise
    npic_cpu_model_i.do_op(NPIC_OP_MASK, NPIC_LVL0);
    wr(NPIC_EXTCTL_ADDR, 32'hcc);
    npic_cpu_model_i.do_op(NPIC_OP_UNMASK, NPIC_LVL0);
    for (i = 0; i < 2; i++)
    begin
      ext_port_b[4] <= 1'(i);
      serve(5, NPIC_LVL3);
      npic_cpu_model_i.do_op(NPIC_OP_RET, NPIC_LVL0);
    end
    // Halt wake: timer refused, spi only in slave mode
    npic_cpu_model_i.do_op(NPIC_OP_HALT, NPIC_LVL0);
    src[3] <= 1'b1;
    src[2] <= 1'b1;
    repeat (4) @(posedge hclk);
    chk_v("halt_wake", 16'h0, 16'(halt_wake));
    spi_slave_mode <= 1'b1;
    repeat (4) @(posedge hclk);
    chk_v("halt_wake", 16'h1, 16'(halt_wake));
    // Time base wakes only from active halt
    src <= 7'h01;
    repeat (4) @(posedge hclk);
    chk_v("halt_wake", 16'h0, 16'(halt_wake));
    npic_cpu_model_i.set_active(1'b1);
    repeat (3) @(posedge hclk);
    chk_v("halt_wake", 16'h1, 16'(halt_wake));
    src <= '0;
    close_out();
  end
endmodule
`default_nettype wire
